/* File: dv/rss_cmd_model.sv */
// Command source model: start levels and main speed command
`timescale 1ns/1ps
`default_nettype none
module rss_cmd_model
    import rss_pkg::*;
(
    input wire logic clk_sys_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic [2:0] req_i, // Bench request {rev,fwd,net}
    input wire rss_freq_t speed_i, // Bench speed
    output logic [2:0] cmd_o, // Start levels and source {rev,fwd,net}
    output rss_freq_t net_cmd_o, // Network command
    output rss_freq_t pnl_cmd_o // Panel command
);
    // Unselected source carries the inverse, so a wrong pick shows
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_o <= 3'h0;
            net_cmd_o <= 16'h0000;
            pnl_cmd_o <= 16'h0000;
        end else begin
            cmd_o <= req_i;
            net_cmd_o <= req_i[0] ? speed_i : ~speed_i;
            pnl_cmd_o <= req_i[0] ? ~speed_i : speed_i;
        end
    end
endmodule : rss_cmd_model
`default_nettype wire

/* File: dv/test_remote_speed_setpoint.sv */
// Self-checking bench for the remote setpoint block
`timescale 1ns/1ps
`default_nettype none
module test_remote_speed_setpoint;
    import rss_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, wreq, nwr, auxi;
    logic inc = 0, dec = 0, clr = 0, sfs = 0, jog = 0, pid = 0, aux = 0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, q, rdat;
    logic [2:0] req = 3'h0, cmd, ms;
    logic [16:0] sf;
    rss_freq_t spd = 16'h0000, nvs = 16'h000c, ncmd, pcmd, off, acc, dcl, nwd;
    int n_mismatch = 0, n_compared = 0;
    // Memory keeps each written word
    always @(posedge clk) if (nwr) nvs <= nwd;
    // Free-running clock, 8 ns period
    initial begin
        forever #4 clk = ~clk;
    end
    // Design with a short idle interval
    rss_top #(.IDLE_CYCLES(36'd50)) dut (.clk_sys_i(clk), .rst_i(rst), .ce_i(1'b1),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .increase_request_i(inc), .decrease_request_i(dec), .clear_request_i(clr),
        .forward_start_i(cmd[1]), .reverse_start_i(cmd[2]), .second_function_select_i(sfs),
        .jog_active_i(jog), .pid_active_i(pid), .network_mode_i(cmd[0]),
        .network_freq_cmd_i(ncmd), .operator_panel_freq_cmd_i(pcmd), .aux_supply_i(aux),
        .nv_stored_i(nvs), .set_freq_o(sf), .remote_offset_o(off), .accel_time_o(acc),
        .decel_time_o(dcl), .multi_speed_sel_o(ms), .aux_supply_indicator_o(auxi),
        .nv_wr_o(nwr), .nv_wdata_o(nwd));
    // Far-side command source
    rss_cmd_model cmdm (.clk_sys_i(clk), .rst_i(rst), .req_i(req), .speed_i(spd),
        .cmd_o(cmd), .net_cmd_o(ncmd), .pnl_cmd_o(pcmd));
    task tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge clk) {rd, wr, adr, wd} <= {~w, w, a, d};
        @(posedge clk);
        for (i = 0; i < 20 && wreq !== 1'b0; i++) @(posedge clk);
        q = rdat;
        {rd, wr} <= 2'b00;
        if (i == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : bus
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    // Bounded wait for the offset to reach a value
    task wo(input rss_freq_t e);
        int i;
        for (i = 0; i < 300 && off !== e; i++) @(posedge clk);
        chk("offset", e, off);
        if (i == 300) tally_and_finish();
    endtask : wo
    // Watch for a store strobe over n cycles
    task ww(input int n, input logic s, input rss_freq_t e);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            @(posedge clk);
            #1;
            seen = (nwr === 1'b1);
        end
        chk("store strobe", s, seen);
        if (s) chk("store data", e, nwd);
    endtask : ww
    task t_regs();
        bus(1'b0, 6'h04, 0);
        chk("maxf", 32'h1770, q);
        bus(1'b0, 6'h10, 0);
        chk("acc2", 32'h0100, q);
        bus(1'b0, 6'h00, 0);
        chk("mode", 32'h0, q);
        bus(1'b1, 6'h24, 32'hffff);
        bus(1'b0, 6'h24, 0);
        chk("unmapped", 32'h0, q);
        $display("test regs done");
    endtask : t_regs
    task t_restore();
        bus(1'b1, 6'h00, 32'h1);
        wo(16'h000c);
        $display("test restore done");
    endtask : t_restore
    task t_multi();
        bus(1'b1, 6'h00, 32'h0);
        @(posedge clk) {inc, clr} <= 2'b11;
        wt(3);
        chk("multi sel", 3'b101, ms);
        bus(1'b1, 6'h00, 32'h2);
        wt(3);
        chk("multi sel", 3'b000, ms);
        wo(16'h0000);
        @(posedge clk) {inc, clr} <= 2'b00;
        $display("test multi done");
    endtask : t_multi
    task t_step();
        for (int a = 8; a <= 20; a += 4) bus(1'b1, 6'(a), 32'h0);
        bus(1'b1, 6'h04, 32'h14);
        @(posedge clk) {spd, req, inc} <= {16'h0100, 3'b001, 1'b1};
        wo(16'h0014);
        wt(8);
        chk("offset", 32'h14, off);
        chk("total", 32'h114, sf);
        @(posedge clk) {spd, req} <= {16'h0200, 3'b000};
        wt(4);
        chk("total", 32'h214, sf);
        @(posedge clk) {inc, dec} <= 2'b01;
        wo(16'h0000);
        @(posedge clk) dec <= 1'b0;
        $display("test step done");
    endtask : t_step
    task t_gate();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) inc <= 1'b1;
            wo(16'h0014);
            @(posedge clk) {pid, jog, inc, clr} <= k ? 4'b1001 : 4'b0101;
            wt(6);
            chk("offset", 32'h14, off);
            chk("total", 32'h200, sf);
            @(posedge clk) {pid, jog} <= 2'b00;
            wo(16'h0000);
            @(posedge clk) clr <= 1'b0;
        end
        $display("test gate done");
    endtask : t_gate
    task t_store();
        bus(1'b1, 6'h00, 32'h1);
        @(posedge clk) {req, inc} <= 4'b0101;
        wo(16'h0014);
        @(posedge clk) {req, inc} <= 4'b0000;
        ww(8, 1'b1, 16'h0014);
        @(posedge clk) {req, clr} <= 4'b1001;
        wo(16'h0000);
        @(posedge clk) clr <= 1'b0;
        ww(80, 1'b1, 16'h0000);
        ww(80, 1'b0, 16'h0000);
        @(posedge clk) aux <= 1'b1;
        ww(8, 1'b1, 16'h0000);
        chk("aux indication", 1'b1, auxi);
        @(posedge clk) {req, aux} <= 4'b0000;
        ww(8, 1'b1, 16'h0000);
        $display("test store done");
    endtask : t_store
    task t_clr_stop();
        bus(1'b1, 6'h00, 32'h3);
        @(posedge clk) {req, inc} <= 4'b0101;
        wo(16'h0014);
        @(posedge clk) {req, inc} <= 4'b0000;
        wo(16'h0000);
        $display("test clear on stop done");
    endtask : t_clr_stop
    task t_ramp();
        bus(1'b1, 6'h08, 32'h5);
        bus(1'b1, 6'h0c, 32'h2);
        bus(1'b1, 6'h10, 32'h3);
        bus(1'b1, 6'h14, 32'h4);
        wt(4);
        chk("accel", 32'h5, acc);
        chk("decel", 32'h2, dcl);
        @(posedge clk) inc <= 1'b1;
        wt(4);
        chk("accel", 32'h5, acc);
        chk("decel", 32'h4, dcl);
        @(posedge clk) sfs <= 1'b1;
        wt(4);
        chk("accel", 32'h3, acc);
        chk("decel", 32'h4, dcl);
        $display("test ramp done");
    endtask : t_ramp
    task t_power();
        bus(1'b1, 6'h00, 32'h1);
        @(posedge clk) {sfs, inc} <= 2'b01;
        wo(16'h0014);
        @(posedge clk) inc <= 1'b0;
        ww(80, 1'b1, 16'h0014);
        @(posedge clk) clr <= 1'b1;
        wo(16'h0000);
        @(posedge clk) {clr, rst} <= 2'b01;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 6'h00, 32'h1);
        wo(16'h0014);
        @(posedge clk) clr <= 1'b1;
        wo(16'h0000);
        @(posedge clk) clr <= 1'b0;
        ww(80, 1'b1, 16'h0000);
        $display("test power return done");
    endtask : t_power
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_restore();
        t_multi();
        t_step();
        t_gate();
        t_store();
        t_clr_stop();
        t_ramp();
        t_power();
        tally_and_finish();
    end
endmodule : test_remote_speed_setpoint
`default_nettype wire

/* File: rtl/rss_map.svh */
// Register offsets, field positions, reset values and timing counts of the remote setpoint block
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// Byte offsets of the word registers
`define RSS_REG_CTRL 6'h00
`define RSS_REG_MAXF 6'h04
`define RSS_REG_ACC1 6'h08
`define RSS_REG_DEC1 6'h0c
`define RSS_REG_ACC2 6'h10
`define RSS_REG_DEC2 6'h14
`define RSS_REG_STAT 6'h18
`define RSS_REG_SHAD 6'h1c
`define RSS_REG_TOTAL 6'h20

// Field positions
`define RSS_CTRL_MODE_LSB 0
`define RSS_STAT_ACTIVE_BIT 16
`define RSS_STAT_AUX_BIT 17
`define RSS_STAT_PEND_BIT 18

// Reset values
`define RSS_MAXF_RST 16'h1770
`define RSS_TIME_RST 16'h0100

// Storage interval: time in seconds, clock rate, derived cycle count
`define RSS_IDLE_TIME_S 64'd60
`define RSS_CLK_HZ 64'd125000000
`define RSS_IDLE_CYCLES (`RSS_IDLE_TIME_S * `RSS_CLK_HZ)

`endif

/* File: rtl/rss_nv_if.sv */
// Link between the setpoint core and the nonvolatile store controller
`timescale 1ns/1ps
`default_nettype none
interface rss_nv_if;
    import rss_pkg::*;
    logic store_en;
    logic idle;
    logic store_now;
    logic restore_ld;
    rss_freq_t restore_val;
    rss_freq_t offset;
    rss_freq_t shadow;
    logic wr;
    rss_freq_t wdata;
    modport core (output store_en, idle, store_now, restore_ld, restore_val, offset,
                  input shadow, wr, wdata);
    modport store (input store_en, idle, store_now, restore_ld, restore_val, offset,
                   output shadow, wr, wdata);
endinterface : rss_nv_if
`default_nettype wire

/* File: rtl/rss_nv_store.sv */
// Nonvolatile store controller with idle interval timer
`timescale 1ns/1ps
`default_nettype none
`include "rss_map.svh"
module rss_nv_store
    import rss_pkg::*;
#(
    parameter logic [35:0] IDLE_CYCLES = 36'(`RSS_IDLE_CYCLES)
) (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_i, // Async reset, active high
    input wire logic ce_i, // Clock enable
    rss_nv_if.store nv // Core side
);
    logic [35:0] idle_cnt;
    logic tick;

    assign tick = nv.idle && (idle_cnt == IDLE_CYCLES - 36'h1);

    // Interval counter, restarted while adjusting
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt <= 36'h0;
        end else if (ce_i) begin
            if (!nv.idle || tick) begin
                idle_cnt <= 36'h0;
            end else begin
                idle_cnt <= idle_cnt + 36'h1;
            end
        end
    end

    // Write strobe, data and last stored copy
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            nv.wr <= 1'b0;
            nv.wdata <= 16'h0;
            nv.shadow <= 16'h0;
        end else if (ce_i) begin
            nv.wr <= 1'b0;
            if (nv.restore_ld) begin
                nv.shadow <= nv.restore_val;
            end else if (nv.store_en && (nv.store_now || (tick && nv.offset != nv.shadow))) begin
                nv.wr <= 1'b1;
                nv.wdata <= nv.offset;
                nv.shadow <= nv.offset;
            end
        end
    end

    a_idle_restart: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !nv.idle) |=> (idle_cnt == 36'h0))
        else $error("interval timer not restarted while adjusting");
    a_store_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && nv.store_en && nv.store_now && !nv.restore_ld) |=> (nv.wr && nv.wdata == $past(nv.offset)))
        else $error("store request did not write the setpoint");
    a_no_dup_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !nv.store_now && nv.offset == nv.shadow) |=> !nv.wr)
        else $error("unchanged setpoint written");
endmodule : rss_nv_store
`default_nettype wire

/* File: rtl/rss_pkg.sv */
// Types shared by the remote setpoint block
package rss_pkg;
    typedef enum logic [1:0] {
        RSS_MODE_MULTI,
        RSS_MODE_STORE,
        RSS_MODE_VOLATILE,
        RSS_MODE_CLR_ON_STOP
    } rss_mode_e;
    typedef logic [15:0] rss_freq_t;
endpackage : rss_pkg

/* File: rtl/rss_ramp_sel.sv */
// Ramp time selection for one direction
`timescale 1ns/1ps
`default_nettype none
`include "rss_map.svh"
module rss_ramp_sel
    import rss_pkg::*;
(
    input wire logic clk_sys_i, // System clock
    input wire logic rst_i, // Async reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic adjusting_i, // Increase or decrease active
    input wire logic sfs_i, // Second function select
    input wire rss_freq_t primary_i, // Primary ramp time
    input wire rss_freq_t second_i, // Second ramp time
    output rss_freq_t time_o // Selected ramp time
);
    // Pick the ramp time for the present conditions
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            time_o <= `RSS_TIME_RST;
        end else if (ce_i) begin
            if (sfs_i) begin
                time_o <= second_i;
            end else if (adjusting_i) begin
                time_o <= (primary_i > second_i) ? primary_i : second_i;
            end else begin
                time_o <= primary_i;
            end
        end
    end

    a_sfs_second: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && sfs_i) |=> (time_o == $past(second_i)))
        else $error("second ramp time not chosen under second function select");
    a_adjust_longer: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !sfs_i && adjusting_i) |=> (time_o >= $past(second_i) && time_o >= $past(primary_i)))
        else $error("adjust ramp time shorter than the longer setting");
endmodule : rss_ramp_sel
`default_nettype wire

/* File: rtl/rss_top.sv */
// Remote frequency setpoint core with Avalon-MM register slave
//
// Contract
// - Mode selects multi-speed, stored, volatile, clear-on-stop
// - Remote modes remap inputs to increase, decrease, clear
// - Offset adds to network or panel command
// - Stored mode writes setpoint when start drops
// - Idle minute compare, write only on change
// - Aux supply switch while running stores setpoint
// - Stored mode restores setpoint at power-up
// - Offset limited between zero and maximum frequency
// - Adjusting uses longer of primary, second times
// - Second function select forces second ramp times
// - Setpoint adjusts even without a start signal
// - Jog or PID disables remote setting
// - Early power return keeps old stored setpoint
// - Late power return starts from cleared setpoint
`timescale 1ns/1ps
`default_nettype none
`include "rss_map.svh"
module rss_top
    import rss_pkg::*;
#(
    parameter logic [35:0] IDLE_CYCLES = 36'(`RSS_IDLE_CYCLES)
) (
    input wire logic clk_sys_i, // System clock, 125 MHz
    input wire logic rst_i, // Async reset, active high
    input wire logic ce_i, // Clock enable, freezes state when low
    input wire logic [5:0] avs_address_i, // Byte address
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [31:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i, // Byte lanes
    output logic [31:0] avs_readdata_o, // Read data
    output logic avs_waitrequest_o, // Stall until answer
    input wire logic increase_request_i, // Raise input
    input wire logic decrease_request_i, // Lower input
    input wire logic clear_request_i, // Clear input
    input wire logic forward_start_i, // Forward start
    input wire logic reverse_start_i, // Reverse start
    input wire logic second_function_select_i, // Second function select
    input wire logic jog_active_i, // Jog operation active
    input wire logic pid_active_i, // PID control active
    input wire logic network_mode_i, // 1 network, 0 operator panel
    input wire rss_freq_t network_freq_cmd_i, // Network main command
    input wire rss_freq_t operator_panel_freq_cmd_i, // Panel main command
    input wire logic aux_supply_i, // Running from auxiliary supply
    input wire rss_freq_t nv_stored_i, // Word held in nonvolatile memory
    output logic [16:0] set_freq_o, // Total set frequency
    output rss_freq_t remote_offset_o, // Remote offset
    output rss_freq_t accel_time_o, // Active acceleration time
    output rss_freq_t decel_time_o, // Active deceleration time
    output logic [2:0] multi_speed_sel_o, // Multi-speed selects
    output logic aux_supply_indicator_o, // Auxiliary supply indication
    output logic nv_wr_o, // Nonvolatile write strobe
    output rss_freq_t nv_wdata_o // Nonvolatile write data
);
    rss_nv_if nv_if ();

    rss_mode_e remote_mode_select;
    rss_freq_t max_frequency_limit;
    rss_freq_t primary_accel_time;
    rss_freq_t primary_decel_time;
    rss_freq_t second_ramp_time;
    rss_freq_t second_decel_time;
    rss_freq_t offset;
    logic restore_pend;
    logic restore_ld;
    logic store_now;
    logic start_prev;
    logic aux_prev;
    rss_freq_t step_cnt;
    logic [31:0] wmask;
    logic [31:0] rd_mux;
    logic bus_req;
    logic bus_wr;
    logic remote_en;
    logic start_now;
    logic start_fall;
    logic adjusting;
    logic step_up;
    logic step_dn;
    rss_freq_t step_time;
    rss_freq_t main_cmd;
    rss_freq_t acc_sel;
    rss_freq_t dec_sel;

    // Request decode; a write lands on the edge where waitrequest is seen low
    assign bus_req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    assign bus_wr = avs_write_i && !avs_waitrequest_o;
    assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // Block conditions
    assign remote_en = (remote_mode_select != RSS_MODE_MULTI) && !jog_active_i && !pid_active_i;
    assign start_now = forward_start_i || reverse_start_i;
    assign start_fall = start_prev && !start_now;
    assign adjusting = increase_request_i || decrease_request_i;
    assign step_up = remote_en && increase_request_i && !decrease_request_i;
    assign step_dn = remote_en && decrease_request_i && !increase_request_i;
    assign step_time = step_up ? acc_sel : dec_sel;
    assign main_cmd = network_mode_i ? network_freq_cmd_i : operator_panel_freq_cmd_i;

    // Read data selection
    always_comb begin
        rd_mux = 32'h0;
        unique case (avs_address_i)
            `RSS_REG_CTRL: rd_mux = {30'h0, remote_mode_select};
            `RSS_REG_MAXF: rd_mux = {16'h0, max_frequency_limit};
            `RSS_REG_ACC1: rd_mux = {16'h0, primary_accel_time};
            `RSS_REG_DEC1: rd_mux = {16'h0, primary_decel_time};
            `RSS_REG_ACC2: rd_mux = {16'h0, second_ramp_time};
            `RSS_REG_DEC2: rd_mux = {16'h0, second_decel_time};
            `RSS_REG_STAT: rd_mux = {13'h0, restore_pend, aux_supply_indicator_o, remote_en, offset};
            `RSS_REG_SHAD: rd_mux = {16'h0, nv_if.shadow};
            `RSS_REG_TOTAL: rd_mux = {15'h0, set_freq_o};
            default: rd_mux = 32'h0;
        endcase
    end

    // Bus handshake: one wait cycle, then answer for one cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else if (ce_i) begin
            if (bus_req) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= avs_read_i ? rd_mux : 32'h0;
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    // Configuration registers with byte lanes
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            remote_mode_select <= RSS_MODE_MULTI;
            max_frequency_limit <= `RSS_MAXF_RST;
            primary_accel_time <= `RSS_TIME_RST;
            primary_decel_time <= `RSS_TIME_RST;
            second_ramp_time <= `RSS_TIME_RST;
            second_decel_time <= `RSS_TIME_RST;
        end else if (ce_i && bus_wr) begin
            unique case (avs_address_i)
                `RSS_REG_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        remote_mode_select <= rss_mode_e'(avs_writedata_i[`RSS_CTRL_MODE_LSB +: 2]);
                    end
                end
                `RSS_REG_MAXF: max_frequency_limit <= (max_frequency_limit & ~wmask[15:0])
                                                      | (avs_writedata_i[15:0] & wmask[15:0]);
                `RSS_REG_ACC1: primary_accel_time <= (primary_accel_time & ~wmask[15:0])
                                                     | (avs_writedata_i[15:0] & wmask[15:0]);
                `RSS_REG_DEC1: primary_decel_time <= (primary_decel_time & ~wmask[15:0])
                                                     | (avs_writedata_i[15:0] & wmask[15:0]);
                `RSS_REG_ACC2: second_ramp_time <= (second_ramp_time & ~wmask[15:0])
                                                   | (avs_writedata_i[15:0] & wmask[15:0]);
                `RSS_REG_DEC2: second_decel_time <= (second_decel_time & ~wmask[15:0])
                                                    | (avs_writedata_i[15:0] & wmask[15:0]);
                default: ;
            endcase
        end
    end

    // Power-up restore: first mode write decides, stored mode loads memory word
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            restore_pend <= 1'b1;
            restore_ld <= 1'b0;
        end else if (ce_i) begin
            restore_ld <= 1'b0;
            if (restore_pend && bus_wr && avs_address_i == `RSS_REG_CTRL && avs_byteenable_i[0]) begin
                restore_pend <= 1'b0;
                restore_ld <= (avs_writedata_i[`RSS_CTRL_MODE_LSB +: 2] == 2'(RSS_MODE_STORE));
            end
        end
    end

    // Start and auxiliary supply edge tracking, storage requests
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            start_prev <= 1'b0;
            aux_prev <= 1'b0;
            store_now <= 1'b0;
            aux_supply_indicator_o <= 1'b0;
        end else if (ce_i) begin
            start_prev <= start_now;
            aux_prev <= aux_supply_i;
            aux_supply_indicator_o <= aux_supply_i;
            store_now <= start_fall || (aux_supply_i && !aux_prev && start_now);
        end
    end

    // Step pacing counter for ramped adjustment
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt <= 16'h0;
        end else if (ce_i) begin
            if ((step_up || step_dn) && step_cnt < step_time) begin
                step_cnt <= step_cnt + 16'h1;
            end else begin
                step_cnt <= 16'h0;
            end
        end
    end

    // Remote offset: restore, clear, clamp, step
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            offset <= 16'h0;
        end else if (ce_i) begin
            if (restore_ld) begin
                offset <= (nv_stored_i > max_frequency_limit) ? max_frequency_limit : nv_stored_i;
            end else if (remote_mode_select == RSS_MODE_CLR_ON_STOP && start_fall) begin
                offset <= 16'h0;
            end else if (remote_en && clear_request_i) begin
                offset <= 16'h0;
            end else if (offset > max_frequency_limit) begin
                offset <= max_frequency_limit;
            end else if ((step_up || step_dn) && step_cnt >= step_time) begin
                if (step_up && offset < max_frequency_limit) begin
                    offset <= offset + 16'h1;
                end else if (step_dn && offset != 16'h0) begin
                    offset <= offset - 16'h1;
                end
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            set_freq_o <= 17'h0;
            remote_offset_o <= 16'h0;
            multi_speed_sel_o <= 3'h0;
            accel_time_o <= `RSS_TIME_RST;
            decel_time_o <= `RSS_TIME_RST;
            nv_wr_o <= 1'b0;
            nv_wdata_o <= 16'h0;
        end else if (ce_i) begin
            set_freq_o <= {1'b0, main_cmd} + {1'b0, remote_en ? offset : 16'h0};
            remote_offset_o <= offset;
            multi_speed_sel_o <= (remote_mode_select == RSS_MODE_MULTI)
                ? {increase_request_i, decrease_request_i, clear_request_i} : 3'h0;
            accel_time_o <= acc_sel;
            decel_time_o <= dec_sel;
            nv_wr_o <= nv_if.wr;
            nv_wdata_o <= nv_if.wdata;
        end
    end

    // Store controller hookup
    assign nv_if.store_en = (remote_mode_select == RSS_MODE_STORE);
    assign nv_if.idle = !adjusting;
    assign nv_if.store_now = store_now;
    assign nv_if.restore_ld = restore_ld;
    assign nv_if.restore_val = nv_stored_i;
    assign nv_if.offset = offset;

    rss_nv_store #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_store (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .nv(nv_if.store)
    );

    rss_ramp_sel u_acc_sel (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .adjusting_i(adjusting),
        .sfs_i(second_function_select_i),
        .primary_i(primary_accel_time),
        .second_i(second_ramp_time),
        .time_o(acc_sel)
    );

    rss_ramp_sel u_dec_sel (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .adjusting_i(adjusting),
        .sfs_i(second_function_select_i),
        .primary_i(primary_decel_time),
        .second_i(second_decel_time),
        .time_o(dec_sel)
    );

    // Checks
    a_offset_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !restore_ld && !(bus_wr && avs_address_i == `RSS_REG_MAXF)) |=> (offset <= max_frequency_limit))
        else $error("remote offset above maximum frequency");
    a_total_sum: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i |=> (set_freq_o == {1'b0, $past(main_cmd)} + {1'b0, $past(remote_en) ? $past(offset) : 16'h0}))
        else $error("set frequency is not main plus offset");
    a_disabled_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !remote_en && !restore_ld && !start_fall && offset <= max_frequency_limit) |=> $stable(offset))
        else $error("offset moved while remote setting disabled");
    a_clear_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && remote_en && clear_request_i && !restore_ld) |=> (offset == 16'h0))
        else $error("clear input did not zero the offset");
    a_stop_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && remote_mode_select == RSS_MODE_CLR_ON_STOP && start_fall && !restore_ld) |=> (offset == 16'h0))
        else $error("start release did not clear offset in clear-on-stop mode");
    a_start_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && start_fall) |=> store_now)
        else $error("start release did not request a store");
    a_msel_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && remote_mode_select != RSS_MODE_MULTI) |=> (multi_speed_sel_o == 3'h0))
        else $error("multi-speed selects active in remote mode");
    a_restore_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && restore_ld && nv_stored_i <= max_frequency_limit) |=> (offset == $past(nv_stored_i)))
        else $error("stored setpoint not restored");
endmodule : rss_top
`default_nettype wire
